// File: include/selfprog_pkg.sv
// Constants and types for the flash self-programming controller.
// Assumes a 40 MHz CPU clock and a 32-bit classic Wishbone slave port.
package selfprog_pkg;

  // Register byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;

  // Control/status register bits
  localparam int EN_BIT    = 0;
  localparam int ERASE_BIT = 1;
  localparam int WRITE_BIT = 2;
  localparam int LOCK_BIT  = 3;
  localparam int REEN_BIT  = 4;
  localparam int SIG_BIT   = 5;
  localparam int BUSY_BIT  = 6;
  localparam int IE_BIT    = 7;

  // Status register bits
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_OP_BIT   = 1;
  localparam int STAT_EE_BIT   = 2;

  // Instruction windows after the arming write
  localparam logic [2:0] STORE_WINDOW = 3'h4;
  localparam logic [2:0] LOAD_WINDOW  = 3'h3;

  // Readback pointer values
  localparam logic [15:0] PTR_FUSE_LOW  = 16'h0000;
  localparam logic [15:0] PTR_LOCK      = 16'h0001;
  localparam logic [15:0] PTR_FUSE_EXT  = 16'h0002;
  localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;
  localparam logic [15:0] PTR_SIG1      = 16'h0000;
  localparam logic [15:0] PTR_CAL       = 16'h0001;
  localparam logic [15:0] PTR_SIG2      = 16'h0002;
  localparam logic [15:0] PTR_SIG3      = 16'h0004;
  localparam logic [1:0]  LOCK_RD_TOP   = 2'h3;
  localparam logic [7:0]  RESERVED_RD   = 8'hff;

  // Pointer fields
  localparam int WORD_LSB = 1;
  localparam int WORD_W   = 6;
  localparam int PAGE_LSB = 7;
  localparam int PAGE_W   = 8;
  localparam int BUF_WORDS = 64;
  localparam logic [15:0] BUF_ERASED = 16'hffff;

  // Programming time
  localparam int CLK_PERIOD_NS    = 25;
  localparam int PROG_TIME_MIN_US = 3700;
  localparam int PROG_TIME_MAX_US = 4500;
  localparam int PROG_CYCLES_MIN =
    (PROG_TIME_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_CYCLES_MAX = (PROG_TIME_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int PROG_CNT_W = 18;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ARMED = 3'b010,
    ST_PROG  = 3'b100
  } seq_state_t;

  typedef enum logic [4:0] {
    CMD_LOAD  = 5'b00001,
    CMD_ERASE = 5'b00010,
    CMD_WRITE = 5'b00100,
    CMD_LOCK  = 5'b01000,
    CMD_REEN  = 5'b10000
  } cmd_t;

  // CPU instruction strobes; data is {r1, r0}
  typedef struct packed {
    logic        store;
    logic        load;
    logic [15:0] ptr;
    logic [15:0] data;
  } cpu_req_t;

  // Non-volatile configuration, programmed bits are zero
  typedef struct packed {
    logic [7:0] fuse_low;
    logic [7:0] fuse_high;
    logic [7:0] fuse_ext;
    logic [5:0] lock;
    logic [7:0] cal;
  } nv_bits_t;

  // Start pulses to the flash array
  typedef struct packed {
    logic        erase;
    logic        write;
    logic        lock;
    logic [7:0]  page;
    logic [5:0]  lock_mask;
  } flash_cmd_t;

endpackage

// File: logic/page_buffer.sv
// Temporary page buffer, one word per slot, each slot writable once.
// Assumes the owner clears it after page write, re-enable and reset.
`timescale 1ns/10ps
module page_buffer (
  // Clock and clear
  input  wire logic                            clk_i,
  input  wire logic                            clear_i,
  // Load port
  input  wire logic                            wr_i,
  input  wire logic [selfprog_pkg::WORD_W-1:0] wr_idx_i,
  input  wire logic [15:0]                     wr_data_i,
  // Flash read port
  input  wire logic [selfprog_pkg::WORD_W-1:0] rd_idx_i,
  output logic      [15:0]                     rd_data_o
);
  import selfprog_pkg::*;

  logic [15:0]          mem_q [BUF_WORDS];
  logic [BUF_WORDS-1:0] used_q;
  logic                 slot_free;

  // A slot written since the last clear keeps its first word
  assign slot_free = !used_q[wr_idx_i];

  always_ff @(posedge clk_i) begin
    if (clear_i) begin
      used_q <= '0;
    end else if (wr_i && slot_free) begin
      used_q[wr_idx_i] <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    for (int i = 0; i < BUF_WORDS; i++) begin
      if (clear_i) begin
        mem_q[i] <= BUF_ERASED;
      end else if (wr_i && slot_free && wr_idx_i == WORD_W'(i)) begin
        mem_q[i] <= wr_data_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    rd_data_o <= mem_q[rd_idx_i];
  end

endmodule

// File: logic/flash_self_program_control.sv
// Flash self-programming sequencer: control register, timed windows,
// configuration readback and timed erase/write/lock operations.
// Assumes a classic Wishbone master and a CPU giving one-cycle strobes.
//
// Chosen here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
module flash_self_program_control #(
  parameter int          PROG_CYCLES = selfprog_pkg::PROG_CYCLES_MIN,
  parameter logic [7:0]  SIG_BYTE1   = 8'h11,  // Arbitrary value
  parameter logic [7:0]  SIG_BYTE2   = 8'h22,  // Arbitrary value
  parameter logic [7:0]  SIG_BYTE3   = 8'h33   // Arbitrary value
) (
  // Clock and resets
  input  wire logic                            clk_i,
  input  wire logic                            rst_i,
  input  wire logic                            por_i,
  // Wishbone slave
  input  wire logic                            wb_cyc_i,
  input  wire logic                            wb_stb_i,
  input  wire logic                            wb_we_i,
  input  wire logic [3:0]                      wb_adr_i,
  input  wire logic [3:0]                      wb_sel_i,
  input  wire logic [31:0]                     wb_dat_i,
  output logic      [31:0]                     wb_dat_o,
  output logic                                 wb_ack_o,
  // CPU instruction side
  input  wire selfprog_pkg::cpu_req_t          cpu_req_i,
  input  wire logic                            eeprom_write_busy_i,
  input  wire selfprog_pkg::nv_bits_t          nv_i,
  output logic      [7:0]                      load_data_o,
  output logic                                 load_cfg_o,
  output logic                                 read_block_o,
  output logic                                 selfprog_irq_o,
  // Flash array side
  output selfprog_pkg::flash_cmd_t             flash_cmd_o,
  input  wire logic [selfprog_pkg::WORD_W-1:0] buf_rd_idx_i,
  output logic      [15:0]                     buf_rd_data_o
);
  import selfprog_pkg::*;

  function automatic cmd_t decode_cmd(input logic er, input logic wr,
                                      input logic lk, input logic re);
    if (re) begin
      return CMD_REEN;
    end else if (lk) begin
      return CMD_LOCK;
    end else if (wr) begin
      return CMD_WRITE;
    end else if (er) begin
      return CMD_ERASE;
    end
    return CMD_LOAD;
  endfunction

  function automatic logic [7:0] read_cfg(input logic sig,
                                          input logic [15:0] ptr,
                                          input nv_bits_t nv);
    if (sig) begin
      case (ptr)
        PTR_SIG1: return SIG_BYTE1;
        PTR_CAL:  return nv.cal;
        PTR_SIG2: return SIG_BYTE2;
        PTR_SIG3: return SIG_BYTE3;
        default:  return RESERVED_RD;
      endcase
    end
    case (ptr)
      PTR_FUSE_LOW:  return nv.fuse_low;
      PTR_LOCK:      return {LOCK_RD_TOP, nv.lock};
      PTR_FUSE_EXT:  return nv.fuse_ext;
      PTR_FUSE_HIGH: return nv.fuse_high;
      default:       return RESERVED_RD;
    endcase
  endfunction

  seq_state_t            state_q;
  seq_state_t            state_d;
  cmd_t                  op_q;
  logic                  en_q;
  logic                  erase_q;
  logic                  write_q;
  logic                  lock_q;
  logic                  reen_q;
  logic                  sig_q;
  logic                  ie_q;
  logic                  busy_q;
  logic [2:0]            wcnt_q;
  logic [PROG_CNT_W-1:0] prog_cnt_q;
  logic                  ack_q;

  // Bus decode
  wire logic  wb_req   = wb_cyc_i && wb_stb_i && !ack_q;
  wire logic  wb_wr    = wb_req && wb_we_i && wb_sel_i[0];
  wire logic  ctrl_hit = wb_adr_i == CTRL_OFS;
  wire logic  stat_hit = wb_adr_i == STAT_OFS;
  wire logic  ctrl_wr  = wb_wr && ctrl_hit;
  wire logic  arm_wr   = ctrl_wr && state_q == ST_IDLE && !eeprom_write_busy_i
                         && wb_dat_i[EN_BIT];

  // Sequence decode
  wire cmd_t  cmd      = decode_cmd(erase_q, write_q, lock_q, reen_q);
  wire logic  armed    = state_q == ST_ARMED;
  wire logic  store_ok = armed && cpu_req_i.store && wcnt_q < STORE_WINDOW
                         && !sig_q && !eeprom_write_busy_i;
  wire logic  load_ok  = armed && cpu_req_i.load && wcnt_q < LOAD_WINDOW
                         && (lock_q || sig_q) && !eeprom_write_busy_i;
  wire logic [2:0] win_last = sig_q ? LOAD_WINDOW - 3'h1 : STORE_WINDOW - 3'h1;
  wire logic  expire   = armed && !store_ok && !load_ok && wcnt_q == win_last;
  wire logic  timed    = store_ok && (cmd == CMD_ERASE || cmd == CMD_WRITE
                         || cmd == CMD_LOCK);
  wire logic  reen_go  = store_ok && cmd == CMD_REEN;
  wire logic  load_go  = store_ok && cmd == CMD_LOAD;
  wire logic  prog_on  = state_q == ST_PROG;
  wire logic  prog_done = prog_on && prog_cnt_q == PROG_CNT_W'(1);
  wire logic  window_end = load_ok || expire || (store_ok && !timed);
  wire logic  buf_clear = rst_i || por_i || reen_go
                          || (prog_done && op_q == CMD_WRITE);

  // Section busy: set by erase/write, held until re-enable
  wire logic  busy_d   = (timed && cmd != CMD_LOCK) ? 1'b1 :
                         reen_go ? 1'b0 : busy_q;

  wire logic [7:0] ctrl_rd = {ie_q, busy_q, sig_q, reen_q, lock_q,
                              write_q, erase_q, en_q};
  wire logic [7:0] stat_rd = {5'h0, eeprom_write_busy_i, prog_on, busy_q};
  wire logic [7:0] rd_byte = ctrl_hit ? ctrl_rd :
                             stat_hit ? stat_rd : 8'h00;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (arm_wr) begin
          state_d = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (timed) begin
          state_d = ST_PROG;
        end else if (window_end) begin
          state_d = ST_IDLE;
        end
      end
      ST_PROG: begin
        if (prog_done) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // Operation in flight survives system reset
  always_ff @(posedge clk_i) begin
    if (por_i || (rst_i && !prog_on)) begin
      state_q    <= ST_IDLE;
      prog_cnt_q <= '0;
      op_q       <= CMD_LOAD;
      busy_q     <= 1'b0;
    end else begin
      state_q <= state_d;
      busy_q  <= busy_d;
      if (timed) begin
        prog_cnt_q <= PROG_CNT_W'(PROG_CYCLES);
        op_q       <= cmd;
      end else if (prog_on) begin
        prog_cnt_q <= prog_cnt_q - PROG_CNT_W'(1);
      end
    end
  end

  // Command bits and window counter
  always_ff @(posedge clk_i) begin
    if (por_i || (rst_i && !prog_on)) begin
      en_q    <= 1'b0;
      erase_q <= 1'b0;
      write_q <= 1'b0;
      lock_q  <= 1'b0;
      reen_q  <= 1'b0;
      sig_q   <= 1'b0;
      wcnt_q  <= '0;
    end else if (arm_wr) begin
      en_q    <= 1'b1;
      erase_q <= wb_dat_i[ERASE_BIT];
      write_q <= wb_dat_i[WRITE_BIT];
      lock_q  <= wb_dat_i[LOCK_BIT];
      reen_q  <= wb_dat_i[REEN_BIT];
      sig_q   <= wb_dat_i[SIG_BIT];
      // Wraps to zero at the ack edge, so the window opens after it
      wcnt_q  <= '1;
    end else if (window_end || prog_done) begin
      en_q    <= 1'b0;
      erase_q <= 1'b0;
      write_q <= 1'b0;
      lock_q  <= 1'b0;
      reen_q  <= 1'b0;
      sig_q   <= 1'b0;
    end else if (armed) begin
      wcnt_q <= wcnt_q + 3'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      ie_q <= 1'b0;
    end else if (ctrl_wr) begin
      ie_q <= wb_dat_i[IE_BIT];
    end
  end

  // Flash start pulses
  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      flash_cmd_o <= '0;
    end else begin
      flash_cmd_o.erase <= timed && cmd == CMD_ERASE;
      flash_cmd_o.write <= timed && cmd == CMD_WRITE;
      flash_cmd_o.lock  <= timed && cmd == CMD_LOCK;
      if (timed) begin
        flash_cmd_o.page      <= cpu_req_i.ptr[PAGE_LSB +: PAGE_W];
        flash_cmd_o.lock_mask <= ~cpu_req_i.data[5:0];
      end
    end
  end

  // Configuration readback
  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      load_cfg_o  <= 1'b0;
      load_data_o <= '0;
    end else begin
      load_cfg_o <= load_ok;
      if (load_ok) begin
        load_data_o <= read_cfg(sig_q, cpu_req_i.ptr, nv_i);
      end
    end
  end

  // Interrupt and bus answer
  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      selfprog_irq_o <= 1'b0;
      ack_q          <= 1'b0;
      wb_dat_o       <= '0;
    end else begin
      selfprog_irq_o <= ie_q && !en_q;
      ack_q          <= wb_req;
      wb_dat_o       <= {24'h0, rd_byte};
    end
  end

  assign wb_ack_o     = ack_q;
  assign read_block_o = busy_q;

  page_buffer u_buf (
    .clk_i     (clk_i),
    .clear_i   (buf_clear),
    .wr_i      (load_go),
    .wr_idx_i  (cpu_req_i.ptr[WORD_LSB +: WORD_W]),
    .wr_data_i (cpu_req_i.data),
    .rd_idx_i  (buf_rd_idx_i),
    .rd_data_o (buf_rd_data_o)
  );

  // Checks
  // Cycles spent in the timed state, for the length check
  logic [PROG_CNT_W-1:0] op_len_q;
  always_ff @(posedge clk_i) begin
    op_len_q <= prog_on ? op_len_q + PROG_CNT_W'(1) : '0;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || por_i);

  irq_level_a: assert property (ie_q && !en_q |=> selfprog_irq_o)
    else $error("interrupt not raised while enable clear");
  erase_block_a: assert property (flash_cmd_o.erase || flash_cmd_o.write |-> read_block_o)
    else $error("section readable during erase or write");
  busy_hold_a: assert property (busy_q && !reen_go |=> busy_q)
    else $error("section busy dropped without re-enable");
  lock_mask_a: assert property (timed && cmd == CMD_LOCK |=>
    flash_cmd_o.lock && flash_cmd_o.lock_mask == ~$past(cpu_req_i.data[5:0]))
    else $error("lock mask wrong");
  lock_open_a: assert property (flash_cmd_o.lock |-> busy_q == $past(busy_q))
    else $error("lock write changed section blocking");
  ee_refuse_a: assert property (eeprom_write_busy_i |=>
    !flash_cmd_o.erase && !flash_cmd_o.write && !flash_cmd_o.lock && !load_cfg_o)
    else $error("operation taken during EEPROM write");
  window_close_a: assert property ($rose(en_q) |-> ##[1:5] (!en_q || prog_on))
    else $error("timed window did not close");
  fuse_low_a: assert property (load_ok && lock_q && cpu_req_i.ptr == PTR_FUSE_LOW |=>
    load_cfg_o && load_data_o == $past(nv_i.fuse_low))
    else $error("fuse low byte readback wrong");
  sig_map_a: assert property (load_ok && sig_q && cpu_req_i.ptr == PTR_SIG2 |=>
    load_data_o == SIG_BYTE2)
    else $error("signature byte 2 wrong");
  prog_time_a: assert property (prog_done |-> op_len_q == PROG_CNT_W'(PROG_CYCLES - 1)
    && en_q)
    else $error("operation length or enable wrong");
  busy_set_a: assert property (timed && cmd != CMD_LOCK |=> busy_q)
    else $error("section busy not set by erase or write");
  reen_open_a: assert property (reen_go |=> !busy_q && !read_block_o)
    else $error("re-enable left the section blocked");
  cfg_normal_a: assert property (!lock_q && !sig_q |=> !load_cfg_o)
    else $error("configuration read while not armed for it");
  sig_clear_a: assert property (armed && sig_q && wcnt_q == 3'h2 |=> !en_q && !sig_q)
    else $error("signature window did not close");
  irq_drop_a: assert property (en_q |=> !selfprog_irq_o)
    else $error("interrupt raised while enable set");

  section_reen_c: cover property (reen_go && busy_q);
  lock_read_c:  cover property (load_ok && lock_q && cpu_req_i.ptr == PTR_LOCK);
  sig_expire_c: cover property (expire && sig_q);
  buf_wipe_c:   cover property (prog_done && op_q == CMD_WRITE);
  slot_load_c:  cover property (load_go);

endmodule

// File: verification/cpu_core_model.sv
// CPU core model issuing store and load program-memory instructions.
// Assumes one-cycle strobes driven after a rising edge of clk_i.
`timescale 1ns/10ps
module cpu_core_model (
  // Clock
  input  wire logic                     clk_i,
  // Instruction strobes
  output selfprog_pkg::cpu_req_t        cpu_req_o,
  // Answers from the controller
  input  wire logic                     load_cfg_i,
  input  wire logic [7:0]               load_data_i,
  input  wire selfprog_pkg::flash_cmd_t flash_cmd_i
);
  import selfprog_pkg::*;

  initial cpu_req_o = '0;  // No vector fetch of its own during programming

  // One instruction gap edges after the arming write, answer taken a cycle later
  task automatic issue(input logic st, input int gap, input logic [15:0] ptr, input logic [15:0] data,
                       output logic cfg, output logic [7:0] rd, output flash_cmd_t cmd);
    repeat (gap) @(posedge clk_i);
    cpu_req_o <= '{store: st, load: !st, ptr: ptr, data: data};
    @(posedge clk_i);
    // Released operands no longer hold their value
    cpu_req_o <= '{store: 1'b0, load: 1'b0, ptr: ~ptr, data: ~data};
    @(posedge clk_i);
    cfg = load_cfg_i;
    rd = load_data_i;
    cmd = flash_cmd_i;
  endtask
endmodule

// File: verification/flash_self_program_control_bench.sv
// Self-checking bench for the flash self-programming controller.
// Assumes the controller package and the CPU core model are compiled first.
`timescale 1ns/10ps
module flash_self_program_control_bench;
  import selfprog_pkg::*;

  localparam int PROG = 20;
  localparam logic [7:0] S1 = 8'h5c;  // Arbitrary value
  localparam logic [7:0] S2 = 8'ha7;  // Arbitrary value
  localparam logic [7:0] S3 = 8'h3e;  // Arbitrary value
  localparam nv_bits_t NV = '{fuse_low: 8'h62, fuse_high: 8'hd9, fuse_ext: 8'hfd, lock: 6'h2a, cal: 8'h9c};
  localparam logic [15:0] RB_PTR [9] = '{PTR_FUSE_LOW, PTR_LOCK, PTR_FUSE_HIGH, PTR_FUSE_EXT,
                                         PTR_SIG1, PTR_CAL, PTR_SIG2, PTR_SIG3, 16'h0006};
  localparam logic [7:0] RB_EXP [9] = '{NV.fuse_low, {LOCK_RD_TOP, NV.lock}, NV.fuse_high, NV.fuse_ext,
                                        S1, NV.cal, S2, S3, RESERVED_RD};

  logic              clk_i;
  logic              rst_i;
  logic              por_i;
  logic              cyc;
  logic              stb;
  logic              we;
  logic              ee_busy;
  logic [3:0]        adr;
  logic [3:0]        sel;
  logic [31:0]       dat_w;
  logic [31:0]       wb_dat_o;
  logic              wb_ack_o;
  logic              load_cfg_o;
  logic              read_block_o;
  logic              selfprog_irq_o;
  logic [7:0]        load_data_o;
  logic [WORD_W-1:0] buf_idx;
  logic [15:0]       buf_rd_data_o;
  cpu_req_t          cpu_req;
  flash_cmd_t        flash_cmd_o;
  logic              cfg_s;
  logic [7:0]        rd_s;
  flash_cmd_t        cmd_s;
  int                error_cnt;
  int                num_checks;
  int                n;

  flash_self_program_control #(.PROG_CYCLES(PROG), .SIG_BYTE1(S1), .SIG_BYTE2(S2), .SIG_BYTE3(S3))
  u_flash_self_program_control (
    .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .cpu_req_i(cpu_req), .eeprom_write_busy_i(ee_busy), .nv_i(NV),
    .load_data_o(load_data_o), .load_cfg_o(load_cfg_o), .read_block_o(read_block_o),
    .selfprog_irq_o(selfprog_irq_o), .flash_cmd_o(flash_cmd_o),
    .buf_rd_idx_i(buf_idx), .buf_rd_data_o(buf_rd_data_o)
  );

  cpu_core_model u_cpu_core_model (
    .clk_i(clk_i), .cpu_req_o(cpu_req), .load_cfg_i(load_cfg_o), .load_data_i(load_data_o),
    .flash_cmd_i(flash_cmd_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic results();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      error_cnt++;
    end
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    dat_w <= {24'h0, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 50) begin
      error_cnt++;
      results();
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] x;
    wb(1'b1, a, d, x);
  endtask

  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] x;
    wb(1'b0, a, 8'h00, x);
    check(x, e);
  endtask

  // Arm the control register, then one instruction gap cycles into its window
  task automatic cmd(input logic [7:0] code, input logic st, input int gap, input logic [15:0] ptr,
                     input logic [15:0] data);
    wr(CTRL_OFS, code);
    u_cpu_core_model.issue(st, gap, ptr, data, cfg_s, rd_s, cmd_s);
  endtask

  task automatic wait_done(output int k);
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (selfprog_irq_o !== 1'b1 && k < 4 * PROG);
    if (k >= 4 * PROG) begin
      error_cnt++;
      results();
    end
  endtask

  task automatic bufchk(input logic [WORD_W-1:0] idx, input logic [15:0] e);
    buf_idx <= idx;
    repeat (2) @(posedge clk_i);
    check(buf_rd_data_o, e);
  endtask

  initial begin
    error_cnt = 0;
    num_checks = 0;
    rst_i = 1'b1;
    por_i = 1'b1;
    {cyc, stb, we, ee_busy} = 4'h0;
    adr = 4'h0;
    sel = 4'h0;
    dat_w = 32'h0;
    buf_idx = '0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    rchk(CTRL_OFS, 32'h0);
    rchk(STAT_OFS, 32'h0);
    rchk(4'h8, 32'h0);
    // Fuse, lock and signature readback across the load window
    for (int i = 0; i < 9; i++) begin
      cmd(i < 4 ? 8'h09 : 8'h21, 1'b0, i % 3, RB_PTR[i], 16'h0);
      check({cfg_s, rd_s}, {1'b1, RB_EXP[i]});
      rchk(CTRL_OFS, 32'h0);
    end
    cmd(8'h09, 1'b0, 3, PTR_LOCK, 16'h0);
    check(cfg_s, 1'b0);
    rchk(CTRL_OFS, 32'h0);
    cmd(8'h21, 1'b0, 3, PTR_SIG1, 16'h0);
    check(cfg_s, 1'b0);
    u_cpu_core_model.issue(1'b0, 0, PTR_LOCK, 16'h0, cfg_s, rd_s, cmd_s);
    check(cfg_s, 1'b0);
    cmd(8'h89, 1'b1, 4, PTR_LOCK, 16'h00c0);
    check(cmd_s, 32'h0);
    rchk(CTRL_OFS, 32'h80);
    check(selfprog_irq_o, 1'b1);
    // Lock write with a system reset in flight
    cmd(8'h89, 1'b1, 3, PTR_LOCK, {8'h00, 2'b11, 6'h35});
    check({cmd_s.erase, cmd_s.write, cmd_s.lock, cmd_s.lock_mask}, {3'b001, 6'h0a});
    check(read_block_o, 1'b0);
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(STAT_OFS, 32'h2);
    wr(CTRL_OFS, 8'h80);
    wait_done(n);
    repeat (5) @(posedge clk_i);
    check(selfprog_irq_o, 1'b1);
    rchk(STAT_OFS, 32'h0);
    // Buffer load, erase, re-enable, write
    cmd(8'h81, 1'b1, 0, 16'h0000, 16'ha5c3);
    cmd(8'h81, 1'b1, 3, 16'h007e, 16'h3c5a);
    cmd(8'h81, 1'b1, 0, 16'h0000, 16'h1111);
    bufchk(6'h00, 16'ha5c3);
    bufchk(6'h3f, 16'h3c5a);
    cmd(8'h83, 1'b1, 2, 16'h2d00, 16'h0);
    check({cmd_s.erase, cmd_s.write, cmd_s.lock, cmd_s.page}, {3'b100, 8'h5a});
    check(read_block_o, 1'b1);
    wait_done(n);
    check(n >= PROG && n <= PROG + 2, 1'b1);
    check(read_block_o, 1'b1);
    rchk(STAT_OFS, 32'h1);
    cmd(8'h91, 1'b1, 0, 16'h0, 16'h0);
    bufchk(6'h3f, BUF_ERASED);
    check(read_block_o, 1'b0);
    cmd(8'h81, 1'b1, 1, 16'h000a, 16'h5aa5);
    cmd(8'h85, 1'b1, 3, 16'h2d00, 16'h0);
    check({cmd_s.erase, cmd_s.write, cmd_s.lock, cmd_s.page}, {3'b010, 8'h5a});
    check(read_block_o, 1'b1);
    wait_done(n);
    check(n >= PROG && n <= PROG + 2, 1'b1);
    bufchk(6'h05, BUF_ERASED);
    // EEPROM write in progress refuses programming and readback
    ee_busy <= 1'b1;
    cmd(8'h89, 1'b1, 0, PTR_LOCK, 16'h00c0);
    check({cmd_s.erase, cmd_s.write, cmd_s.lock}, 3'b000);
    cmd(8'h09, 1'b0, 0, PTR_LOCK, 16'h0);
    check(cfg_s, 1'b0);
    rchk(STAT_OFS, 32'h5);
    ee_busy <= 1'b0;
    results();
  end
endmodule
